// File: hw/cpcc_top.sv
// Design decision made here: the APB interface to the registers.
module cpcc_top
  import cpcc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire cpcc_pkg::cpcc_apb_req_t apbReq,
  output cpcc_pkg::cpcc_apb_rsp_t   apbRsp,
  input  wire logic                 wakeEvent,
  input  wire logic                 subClkTick,
  output logic                      cpuClkEn,
  output logic                      cpuIdle,
  output logic                      cpuStop
);
  import cpcc_pkg::*;

  cpcc_ctrl_t    ctrl_r;
  logic          srcSel_r;
  cpcc_mode_t    mode_r;
  cpcc_mode_t    mode_nxt;
  cpcc_apb_rsp_t rsp_r;
  logic          wake_s1_r;
  logic          wake_s2_r;
  logic          sub_s1_r;
  logic          sub_s2_r;
  logic          sub_s3_r;
  logic [1:0]    subCnt_r;
  logic          mainTick;
  logic [6:0]    mainDiv;

  wire access   = apbReq.psel && apbReq.penable && rsp_r.pready;
  wire hitCtrl  = apbReq.paddr[13:0] == PWR_CTRL_ADDR && apbReq.paddr[15:14] == 2'b00;
  wire hitSrc   = apbReq.paddr[13:0] == SRC_SEL_ADDR && apbReq.paddr[15:14] == 2'b00;
  wire hitStat  = apbReq.paddr[13:0] == STATUS_ADDR && apbReq.paddr[15:14] == 2'b00;
  wire mapped   = hitCtrl || hitSrc || hitStat;
  wire wrCtrl   = access && apbReq.pwrite && hitCtrl;
  wire wrSrc    = access && apbReq.pwrite && hitSrc;
  wire subRise  = sub_s2_r && !sub_s3_r;
  wire subTick  = subRise && subCnt_r == 2'b11;
  wire [1:0] wrMode = apbReq.pwdata[MODE_LSB +: 2];

  // control register is write-only, so reads of it return zero
  wire [31:0] rdData = hitSrc  ? {31'h0, srcSel_r} :
                       hitStat ? {28'h0, srcSel_r, 1'b0, mode_r} :
                       32'h0000_0000;

  // 01 -> divide by 64 like 00
  assign mainDiv = ctrl_r.clkSel == 2'b11 ? 7'(DIV_MAIN_FAST) :
                   ctrl_r.clkSel == 2'b10 ? 7'(DIV_MAIN_MID)  :
                   7'(DIV_MAIN_SLOW);

  cpcc_clk_div #(
    .MAX_DIV (DIV_MAIN_SLOW)
  ) u_main_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .divisor (mainDiv),
    .tick    (mainTick)
  );

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      CPCC_RUN: begin
        if (wrCtrl && wrMode == 2'b01) begin
          mode_nxt = CPCC_IDLE;
        end else if (wrCtrl && wrMode == 2'b10) begin
          mode_nxt = CPCC_STOP;
        end
      end
      CPCC_IDLE, CPCC_STOP: begin
        // power-down ends on a wake event or a write back to run
        if (wake_s2_r || (wrCtrl && (wrMode == 2'b00 || wrMode == 2'b11))) begin
          mode_nxt = CPCC_RUN;
        end
      end
      default: mode_nxt = CPCC_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r   <= PWR_CTRL_RESET;
      srcSel_r <= SRC_SEL_RESET;
      mode_r   <= CPCC_RUN;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= apbReq.pwdata[3:0];
      end
      if (wrSrc) begin
        srcSel_r <= apbReq.pwdata[0];
      end
      mode_r <= mode_nxt;
    end
  end

  // wake and subsystem clock come from outside this clock domain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      sub_s1_r  <= 1'b0;
      sub_s2_r  <= 1'b0;
      sub_s3_r  <= 1'b0;
      subCnt_r  <= 2'b00;
    end else begin
      wake_s1_r <= wakeEvent;
      wake_s2_r <= wake_s1_r;
      sub_s1_r  <= subClkTick;
      sub_s2_r  <= sub_s1_r;
      sub_s3_r  <= sub_s2_r;
      if (subRise) begin
        subCnt_r <= subCnt_r + 2'b01;
      end
    end
  end

  // outputs registered; stop and idle both gate only the cpu clock, the dividers keep running
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpuClkEn <= 1'b0;
      cpuIdle  <= 1'b0;
      cpuStop  <= 1'b0;
    end else begin
      cpuClkEn <= (mode_r == CPCC_RUN) && (srcSel_r ? subTick : mainTick);
      cpuIdle  <= mode_r == CPCC_IDLE;
      cpuStop  <= mode_r == CPCC_STOP;
    end
  end

  // zero-wait apb slave; unmapped addresses answer with pslverr
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready  <= apbReq.psel && !apbReq.penable;
      rsp_r.pslverr <= apbReq.psel && !apbReq.penable && !mapped;
      rsp_r.prdata  <= (apbReq.psel && !apbReq.penable && !apbReq.pwrite) ? rdData : 32'h0000_0000;
    end
  end
  assign apbRsp = rsp_r;

  // tick spacing monitor for the divider checks; a control write voids the
  // interval in flight because the divider compares against a new value at once, mid-interval
  logic [6:0] tickGap_r;
  logic       tickSeen_r;
  logic       divMoved_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tickGap_r  <= 7'h00;
      tickSeen_r <= 1'b0;
      divMoved_r <= 1'b1;
    end else begin
      if (mainTick) begin
        tickGap_r  <= 7'h01;
        tickSeen_r <= 1'b1;
      end else if (tickGap_r != 7'h7F) begin
        tickGap_r <= tickGap_r + 7'd1;
      end
      // a write in the tick cycle wins over the clear
      if (wrCtrl) begin
        divMoved_r <= 1'b1;
      end else if (mainTick) begin
        divMoved_r <= 1'b0;
      end
    end
  end

  // mode machine

  chk_idle_entry: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_RUN && wrCtrl && wrMode == 2'b01
    |=> ##1 cpuIdle)
    else $error("idle not entered after write of 01");

  chk_stop_entry: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_RUN && wrCtrl && wrMode == 2'b10
    |=> ##1 cpuStop)
    else $error("stop not entered after write of 10");

  chk_idle_holds: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_IDLE && !wake_s2_r && !(wrCtrl && wrMode[1] == wrMode[0])
    |=> mode_r == CPCC_IDLE)
    else $error("idle left without cause");

  chk_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_STOP && !wake_s2_r && !(wrCtrl && wrMode[1] == wrMode[0])
    |=> mode_r == CPCC_STOP)
    else $error("stop left without cause");

  chk_exit_wake: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r != CPCC_RUN && wake_s2_r
    |=> mode_r == CPCC_RUN)
    else $error("wake did not restore run");

  chk_run_on_zero: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r != CPCC_RUN && wrCtrl && wrMode == 2'b00
    |=> mode_r == CPCC_RUN)
    else $error("write of 00 did not restore run");

  chk_code11_run: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r != CPCC_RUN && wrCtrl && wrMode == 2'b11
    |=> mode_r == CPCC_RUN)
    else $error("write of 11 did not restore run");

  chk_run_noclk_down: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r != CPCC_RUN
    |=> !cpuClkEn)
    else $error("cpu clock runs in power-down");

  chk_idle_clk_off: assert property (@(posedge clk) disable iff (!rst_b)
    cpuIdle
    |-> !cpuClkEn)
    else $error("cpu clock pulses while idle");

  chk_stop_clk_off: assert property (@(posedge clk) disable iff (!rst_b)
    cpuStop
    |-> !cpuClkEn)
    else $error("cpu clock pulses while stopped");

  chk_flags_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
    cpuIdle
    |-> !cpuStop)
    else $error("idle and stop both shown");

  // clock selection

  chk_div_fast: assert property (@(posedge clk) disable iff (!rst_b)
    mainTick && tickSeen_r && !divMoved_r && ctrl_r.clkSel == 2'b11
    |-> tickGap_r == 7'(DIV_MAIN_FAST))
    else $error("divide by 4 not kept");

  chk_div_mid: assert property (@(posedge clk) disable iff (!rst_b)
    mainTick && tickSeen_r && !divMoved_r && ctrl_r.clkSel == 2'b10
    |-> tickGap_r == 7'(DIV_MAIN_MID))
    else $error("divide by 8 not kept");

  chk_div_undoc: assert property (@(posedge clk) disable iff (!rst_b)
    mainTick && tickSeen_r && !divMoved_r && ctrl_r.clkSel[1] == 1'b0
    |-> tickGap_r == 7'(DIV_MAIN_SLOW))
    else $error("codes 00 and 01 must divide by 64");

  chk_main_follow: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_RUN && !srcSel_r
    |=> cpuClkEn == $past(mainTick))
    else $error("cpu clock not from main divider");

  chk_sub_source: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_RUN && srcSel_r && !subTick
    |=> !cpuClkEn)
    else $error("cpu clock not from subsystem clock");

  chk_sub_follow: assert property (@(posedge clk) disable iff (!rst_b)
    mode_r == CPCC_RUN && srcSel_r
    |=> cpuClkEn == $past(subTick))
    else $error("subsystem tick not passed on");

  chk_sub_count: assert property (@(posedge clk) disable iff (!rst_b)
    subRise
    |=> subCnt_r == $past(subCnt_r) + 2'b01)
    else $error("subsystem edge not counted");

  // register bus

  chk_ready_setup: assert property (@(posedge clk) disable iff (!rst_b)
    apbReq.psel && !apbReq.penable
    |=> rsp_r.pready)
    else $error("pready missing after setup");

  chk_ready_single: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_r.pready
    |=> !rsp_r.pready)
    else $error("pready stood too long");

  chk_err_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
    apbReq.psel && !apbReq.penable && !mapped
    |=> rsp_r.pslverr)
    else $error("unmapped access not flagged");

  chk_err_mapped_clean: assert property (@(posedge clk) disable iff (!rst_b)
    apbReq.psel && !apbReq.penable && mapped
    |=> !rsp_r.pslverr)
    else $error("mapped access flagged");

  chk_wr_only_read: assert property (@(posedge clk) disable iff (!rst_b)
    apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitCtrl
    |=> rsp_r.prdata == 32'h0000_0000)
    else $error("control register read not zero");

  chk_ctrl_store: assert property (@(posedge clk) disable iff (!rst_b)
    wrCtrl
    |=> ctrl_r == $past(apbReq.pwdata[3:0]))
    else $error("control write not stored");

  chk_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wrCtrl
    |=> $stable(ctrl_r))
    else $error("control register changed without write");

  chk_src_store: assert property (@(posedge clk) disable iff (!rst_b)
    wrSrc
    |=> srcSel_r == $past(apbReq.pwdata[0]))
    else $error("source select write not stored");

  chk_src_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wrSrc
    |=> $stable(srcSel_r))
    else $error("source select changed without write");
endmodule : cpcc_top

// File: hw/cpcc_pkg.sv
package cpcc_pkg;
  // register index as printed; byte address is four times it
  localparam logic [11:0] PWR_CTRL_IDX    = 12'h0_FB3;
  localparam logic [13:0] PWR_CTRL_ADDR   = {PWR_CTRL_IDX, 2'b00};
  localparam logic [11:0] SRC_SEL_IDX     = 12'h0_FB4;
  localparam logic [13:0] SRC_SEL_ADDR    = {SRC_SEL_IDX, 2'b00};
  localparam logic [11:0] STATUS_IDX      = 12'h0_FB5;
  localparam logic [13:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};
  localparam int          MODE_LSB        = 2;
  localparam int          CLKSEL_LSB      = 0;
  localparam logic [3:0]  PWR_CTRL_RESET  = 4'h0;
  localparam logic        SRC_SEL_RESET   = 1'b0;
  localparam int          DIV_MAIN_SLOW   = 64;
  localparam int          DIV_MAIN_MID    = 8;
  localparam int          DIV_MAIN_FAST   = 4;
  localparam int          DIV_SUB         = 4;

  typedef enum logic [1:0] {
    CPCC_RUN,
    CPCC_IDLE,
    CPCC_STOP
  } cpcc_mode_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] clkSel;
  } cpcc_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } cpcc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cpcc_apb_rsp_t;
endpackage : cpcc_pkg

// File: hw/cpcc_clk_div.sv
module cpcc_clk_div #(
  parameter int MAX_DIV = 64
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [6:0] divisor,
  output logic            tick
);
  logic [6:0] cnt_r;
  wire        wrapNow = (cnt_r >= divisor - 7'd1);

  // one-cycle tick every divisor cycles; a new divisor takes hold at once in the wrap compare
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrapNow ? 7'h00 : cnt_r + 7'd1;
      tick  <= wrapNow;
    end
  end

  chk_div_range: assert property (@(posedge clk) disable iff (!rst_b)
    divisor != 7'd0 && 32'(divisor) <= MAX_DIV)
    else $error("divisor outside the supported range");
endmodule : cpcc_clk_div

// File: dv/cpcc_top_tb.sv
module cpcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpcc_pkg::*;
  logic          clk;
  logic          rst_b;
  logic          wakeEvent;
  logic          subClkTick;
  logic          subOn;
  logic          cpuClkEn;
  logic          cpuIdle;
  logic          cpuStop;
  int            subCnt;
  int            errCount;
  int            numChecks;
  cpcc_apb_req_t req;
  cpcc_apb_rsp_t rsp;
  cpcc_apb_rsp_t r;

  cpcc_top u_cpcc_top (.clk(clk), .rst_b(rst_b), .apbReq(req), .apbRsp(rsp), .wakeEvent(wakeEvent),
    .subClkTick(subClkTick), .cpuClkEn(cpuClkEn), .cpuIdle(cpuIdle), .cpuStop(cpuStop));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // slow subsystem clock, 10 cycles a period, so its ticks are clearly apart
  always @(posedge clk) begin
    subCnt <= (subCnt == 4) ? 0 : subCnt + 1;
    if (subOn && subCnt == 4) subClkTick <= ~subClkTick;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic apb(input logic [13:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, a}, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    r = rsp;
    req <= '0;
    @(posedge clk);
    check(n < 50, 1'b1, "pready timeout");
  endtask : apb

  // first pulses may be spaced oddly, as the divider applies the new divisor mid-interval
  task automatic period(input int exp, input string msg);
    int n;
    repeat (2) begin
      do @(posedge clk); while (cpuClkEn !== 1'b1);
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpuClkEn !== 1'b1 && n < 300);
    check(n, exp, msg);
  endtask : period

  task automatic tDivide;
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0002);
    period(DIV_MAIN_MID, "div mid");
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0003);
    period(DIV_MAIN_FAST, "div fast");
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0001);
    period(DIV_MAIN_SLOW, "div code 01");
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0000);
    period(DIV_MAIN_SLOW, "div slow");
  endtask : tDivide

  task automatic tSub;
    subOn <= 1'b1;
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0003);
    apb(SRC_SEL_ADDR, 1'b1, 32'h0000_0001);
    period(DIV_SUB * 10, "sub clock");
    apb(SRC_SEL_ADDR, 1'b0, 32'h0000_0000);
    check(r.prdata, 32'h0000_0001, "source readback");
    apb(PWR_CTRL_ADDR, 1'b1, 32'h0000_0000);
    period(DIV_SUB * 10, "sub clock code 00");
    apb(SRC_SEL_ADDR, 1'b1, 32'h0000_0000);
    subOn <= 1'b0;
  endtask : tSub

  task automatic mode(input logic [31:0] d, input logic [1:0] exp, input string msg);
    apb(PWR_CTRL_ADDR, 1'b1, d);
    repeat (3) @(posedge clk);
    check({cpuIdle, cpuStop}, exp, msg);
  endtask : mode

  task automatic tModes;
    mode(32'h0000_0004, 2'b10, "idle entry");
    mode(32'h0000_0000, 2'b00, "run on 00");
    mode(32'h0000_0008, 2'b01, "stop entry");
    apb(STATUS_ADDR, 1'b0, 32'h0000_0000);
    check(r.prdata, 32'h0000_0002, "status in stop");
    check(r.pslverr, 1'b0, "status no error");
    wakeEvent <= 1'b1;
    repeat (5) @(posedge clk);
    wakeEvent <= 1'b0;
    check({cpuIdle, cpuStop}, 2'b00, "wake exit");
    mode(32'h0000_0004, 2'b10, "idle again");
    mode(32'h0000_000C, 2'b00, "code 11 runs");
  endtask : tModes

  task automatic tBus;
    apb(PWR_CTRL_ADDR, 1'b0, 32'h0000_0000);
    check(r.prdata, 32'h0000_0000, "write-only read");
    apb(14'h0010, 1'b0, 32'h0000_0000);
    check(r.pslverr, 1'b1, "unmapped");
  endtask : tBus

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrapUp

  initial begin
    #300us;
    errCount++;
    $display("ERROR at %0t: watchdog", $time);
    wrapUp();
  end

  initial begin
    {rst_b, wakeEvent, subClkTick, subOn, subCnt, req} = '0;
    errCount = 0;
    numChecks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({cpuIdle, cpuStop}, 2'b00, "reset state");
    tBus();
    tDivide();
    tSub();
    tModes();
    wrapUp();
  end
endmodule : cpcc_top_tb
